// ==== lcdic_defines.svh ====
// offsets, memory layout, display geometry and timing counts of the character display core
`ifndef LCDIC_DEFINES_SVH
`define LCDIC_DEFINES_SVH
// ----------------------------------------------------------------
// register map (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define LCDIC_OFS_CMD 8'h00
`define LCDIC_OFS_DATA 8'h04
`define LCDIC_OFS_CFG 8'h08
// ----------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------
`define LCDIC_TEXT_DEPTH 128
`define LCDIC_GLYPH_DEPTH 64
`define LCDIC_SPACE_CODE 8'h20
`define LCDIC_LINE2_BASE 7'h40
`define LCDIC_LINE1_LAST 7'h27
`define LCDIC_LINE2_LAST 7'h67
`define LCDIC_ONE_LINE_LAST 7'h4F
`define LCDIC_LEN_TWO 8'h28
`define LCDIC_LEN_ONE 8'h50
`define LCDIC_SEG_COUNT 40
`define LCDIC_COM_COUNT 16
`define LCDIC_CHARS_SHOWN 8
`define LCDIC_DOTS 5
`define LCDIC_CURSOR_ROW 3'h7
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LCDIC_MCLK_MHZ 40
`define LCDIC_T_EXEC_NS 18500
`define LCDIC_T_CLEAR_NS 760000
`define LCDIC_T_BLINK_US 185000
`define LCDIC_EXEC_CYCLES ((`LCDIC_T_EXEC_NS * `LCDIC_MCLK_MHZ + 999) / 1000)
`define LCDIC_CLEAR_CYCLES ((`LCDIC_T_CLEAR_NS * `LCDIC_MCLK_MHZ + 999) / 1000)
`define LCDIC_BLINK_CYCLES (`LCDIC_T_BLINK_US * `LCDIC_MCLK_MHZ)
`define LCDIC_SCAN_DIV 8
`endif

// ==== lcdic_pkg.sv ====
// types of the character display core
package lcdic_pkg;
	// ----------------------------------------------------------------
	// bus phase
	// ----------------------------------------------------------------
	typedef enum logic [0:0]
	{
		LCDIC_BUS_ADDR = 1'b0,
		LCDIC_BUS_DATA = 1'b1
	} lcdic_bus_e;
	// ----------------------------------------------------------------
	// whole state of the core
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [127:0][7:0] text;
		logic [63:0][7:0] glyph;
		logic [6:0] ac;
		logic ac_glyph;
		logic inc;
		logic shift_en;
		logic disp_on;
		logic cur_on;
		logic blink_on;
		logic bus8;
		logic two_line;
		logic tall_font;
		logic [6:0] shift;
		logic busy;
		logic [15:0] busy_cnt;
		logic clearing;
		logic [6:0] clr_idx;
		logic nib;
		logic [3:0] nib_hold;
		lcdic_bus_e phase;
		logic [7:0] dofs;
		logic dwrite;
		logic [31:0] hrdata;
		logic hreadyout;
		logic [15:0] div_cnt;
		logic [5:0] col;
		logic [3:0] row;
		logic [39:0] sreg;
		logic [39:0] seg;
		logic [15:0] com;
		logic [22:0] blink_cnt;
		logic blink_ph;
	} lcdic_state_s;
endpackage : lcdic_pkg

// ==== lcdic_core.sv ====
// instruction decoder, memories and segment/common driver of the character display core
// Summary of operation
// - two-line rows start at 00H and 40H
// - display shift moves mapping, not stored text
// - counter loads address, steps after data access
// - status read: counter low bits, busy bit7
// - 16 commons two-line, 8 one-line, 40 segments
// - pixels shift serially, then parallel segment transfer
// - fixed table: 240 codes, 5x8 patterns
// - code bits 0-2 pick user glyph
// - counter bits 0-2 row; row 7 ORs cursor
// - bits 0-4 are dots, bit 4 leftmost
// - codes 0x-0Fh user glyphs, bit 3 ignored
// - 01h fills text with 20H, counter 00H
// - home: counter 00H, shift undone, long time
// - entry mode stores direction and shift enable
// - on/off latches display, cursor, blink bits
// - shift display or cursor, right or left
// - function set: bus width, lines, font height (font bit only latched; scan stays 8 rows)
// - glyph or text address loads the counter
// - status read immediate, reports busy and counter
// - data write stores, data read returns byte
// - 4-bit mode: two nibble transfers per byte
//
// The address map and the AHB-Lite slave port were decided locally.
`include "lcdic_defines.svh"
module lcdic_core #(
	parameter int unsigned CLEAR_CYCLES = `LCDIC_CLEAR_CYCLES,
	parameter int unsigned BLINK_CYCLES = `LCDIC_BLINK_CYCLES,
	parameter int unsigned SCAN_DIV = `LCDIC_SCAN_DIV
)(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [39:0] seg_out,
	output logic [15:0] com_out
);
	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	localparam int unsigned EXEC_CYCLES = `LCDIC_EXEC_CYCLES;
	// clear sweeps one text cell a cycle; busy must outlast the sweep
	if (CLEAR_CYCLES < `LCDIC_TEXT_DEPTH || CLEAR_CYCLES > 65535 || BLINK_CYCLES < 1 || BLINK_CYCLES > 8388607
		|| SCAN_DIV < 1 || SCAN_DIV > 65535)
	begin : g_bad
		$error("lcdic_core: parameter out of range");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [6:0] lcdic_step(input logic [6:0] a, input logic up, input logic two);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (two && up && a == `LCDIC_LINE1_LAST)
			r = `LCDIC_LINE2_BASE;
		else if (two && up && a == `LCDIC_LINE2_LAST)
			r = 7'h00;
		else if (two && !up && a == `LCDIC_LINE2_BASE)
			r = `LCDIC_LINE1_LAST;
		else if (two && !up && a == 7'h00)
			r = `LCDIC_LINE2_LAST;
		else if (!two && up && a == `LCDIC_ONE_LINE_LAST)
			r = 7'h00;
		else if (!two && !up && a == 7'h00)
			r = `LCDIC_ONE_LINE_LAST;
		return r;
	endfunction : lcdic_step

	// display offset moves modulo the line length; stored text never moves
	function automatic logic [6:0] lcdic_rot(input logic [6:0] s, input logic right, input logic two);
		logic [7:0] len;
		logic [7:0] n;
		len = two ? `LCDIC_LEN_TWO : `LCDIC_LEN_ONE;
		if (right)
			n = (s == 7'h00) ? len - 8'h01 : {1'b0, s} - 8'h01;
		else
			n = ({1'b0, s} + 8'h01 == len) ? 8'h00 : {1'b0, s} + 8'h01;
		return n[6:0];
	endfunction : lcdic_rot

	function automatic logic [6:0] lcdic_pos_addr(input logic [2:0] pos, input logic line, input logic [6:0] s,
		input logic two);
		logic [7:0] len;
		logic [7:0] i;
		len = two ? `LCDIC_LEN_TWO : `LCDIC_LEN_ONE;
		i = {5'h00, pos} + {1'b0, s};
		if (i >= len)
			i = i - len;
		return (two && line) ? `LCDIC_LINE2_BASE + i[6:0] : i[6:0];
	endfunction : lcdic_pos_addr

	// stand-in pattern source; real glyph art is mask content, not logic
	function automatic logic [4:0] lcdic_fixed(input logic [7:0] code, input logic [2:0] r);
		return (r == `LCDIC_CURSOR_ROW) ? 5'h00 : code[4:0] ^ {2'h0, r};
	endfunction : lcdic_fixed

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	lcdic_pkg::lcdic_state_s s_q;
	lcdic_pkg::lcdic_state_s s_d;
	logic take_q;
	logic exec_cmd;
	logic exec_wr;
	logic exec_rd;
	logic stat_rd;
	logic [7:0] cmd_byte;

	assign hrdata = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	assign hresp = 1'b0 & s_q.hreadyout;
	assign seg_out = s_q.seg;
	assign com_out = s_q.com;
	assign take_q = hsel && hready && s_q.hreadyout && htrans[1];

	always_comb
	begin
		logic complete;
		logic [7:0] byte_in;
		logic [7:0] rd_val;
		logic [7:0] code;
		logic [4:0] pat;
		logic [2:0] chr;
		logic [2:0] dot;
		logic [2:0] grow;
		logic line;
		logic [6:0] pa;
		logic pixel;
		logic [3:0] last_row;
		complete = 1'b0;
		byte_in = 8'h00;
		rd_val = 8'h00;
		code = 8'h00;
		pat = 5'h00;
		chr = 3'h0;
		dot = 3'h0;
		grow = 3'h0;
		line = 1'b0;
		pa = 7'h00;
		pixel = 1'b0;
		last_row = 4'h0;
		s_d = s_q;
		exec_cmd = 1'b0;
		exec_wr = 1'b0;
		exec_rd = 1'b0;
		stat_rd = 1'b0;
		cmd_byte = 8'h00;
		// ------------------------------------------------------------
		// execution timer
		// ------------------------------------------------------------
		if (s_q.busy)
		begin
			if (s_q.busy_cnt == 16'h0000)
				s_d.busy = 1'b0;
			else
				s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
		end
		if (s_q.clearing)
		begin
			s_d.text[s_q.clr_idx] = `LCDIC_SPACE_CODE;
			s_d.clr_idx = s_q.clr_idx + 7'h01;
			if (s_q.clr_idx == 7'h7F)
				s_d.clearing = 1'b0;
		end
		// ------------------------------------------------------------
		// bus slave: one wait state, then registered answer
		// ------------------------------------------------------------
		if (s_q.phase == lcdic_pkg::LCDIC_BUS_ADDR)
		begin
			if (take_q)
			begin
				s_d.phase = lcdic_pkg::LCDIC_BUS_DATA;
				s_d.dofs = haddr[7:0];
				s_d.dwrite = hwrite;
				s_d.hreadyout = 1'b0;
			end
		end
		else
		begin
			s_d.phase = lcdic_pkg::LCDIC_BUS_ADDR;
			s_d.hreadyout = 1'b1;
			s_d.hrdata = 32'h0000_0000;
			if (s_q.dofs == `LCDIC_OFS_CMD || s_q.dofs == `LCDIC_OFS_DATA)
			begin
				if (s_q.dofs == `LCDIC_OFS_CMD)
					rd_val = {s_q.busy, s_q.ac};
				else
					rd_val = s_q.ac_glyph ? s_q.glyph[s_q.ac[5:0]] : s_q.text[s_q.ac];
				if (s_q.bus8)
				begin
					complete = 1'b1;
					byte_in = hwdata[7:0];
					s_d.hrdata = {24'h00_0000, rd_val};
				end
				else if (!s_q.nib)
				begin
					s_d.nib = 1'b1;
					s_d.nib_hold = hwdata[7:4];
					s_d.hrdata = {24'h00_0000, rd_val[7:4], 4'h0};
				end
				else
				begin
					s_d.nib = 1'b0;
					complete = 1'b1;
					byte_in = {s_q.nib_hold, hwdata[7:4]};
					s_d.hrdata = {24'h00_0000, rd_val[3:0], 4'h0};
				end
			end
			else if (s_q.dofs == `LCDIC_OFS_CFG)
				s_d.hrdata = {16'h0000, s_q.ac_glyph, s_q.shift, s_q.bus8, s_q.two_line, s_q.tall_font,
					s_q.inc, s_q.shift_en, s_q.disp_on, s_q.cur_on, s_q.blink_on};
			if (complete && !s_q.busy)
			begin
				exec_cmd = s_q.dwrite && s_q.dofs == `LCDIC_OFS_CMD;
				exec_wr = s_q.dwrite && s_q.dofs == `LCDIC_OFS_DATA;
				exec_rd = !s_q.dwrite && s_q.dofs == `LCDIC_OFS_DATA;
			end
			stat_rd = complete && !s_q.dwrite && s_q.dofs == `LCDIC_OFS_CMD;
		end
		// ------------------------------------------------------------
		// data transfers
		// ------------------------------------------------------------
		if (exec_wr || exec_rd)
		begin
			if (exec_wr && s_q.ac_glyph)
				s_d.glyph[s_q.ac[5:0]] = byte_in;
			else if (exec_wr)
				s_d.text[s_q.ac] = byte_in;
			if (s_q.ac_glyph)
				s_d.ac = {1'b0, s_q.ac[5:0] + (s_q.inc ? 6'h01 : 6'h3F)};
			else
				s_d.ac = lcdic_step(s_q.ac, s_q.inc, s_q.two_line);
			if (exec_wr && !s_q.ac_glyph && s_q.shift_en)
				s_d.shift = lcdic_rot(s_q.shift, !s_q.inc, s_q.two_line);
			s_d.busy = 1'b1;
			s_d.busy_cnt = 16'(EXEC_CYCLES - 1);
		end
		// ------------------------------------------------------------
		// instruction decode by highest set bit
		// ------------------------------------------------------------
		if (exec_cmd)
		begin
			cmd_byte = byte_in;
			s_d.busy = byte_in != 8'h00;
			s_d.busy_cnt = 16'(EXEC_CYCLES - 1);
			if (byte_in[7])
			begin
				s_d.ac = byte_in[6:0];
				s_d.ac_glyph = 1'b0;
			end
			else if (byte_in[6])
			begin
				s_d.ac = {1'b0, byte_in[5:0]};
				s_d.ac_glyph = 1'b1;
			end
			else if (byte_in[5])
			begin
				s_d.bus8 = byte_in[4];
				s_d.two_line = byte_in[3];
				s_d.tall_font = byte_in[2];
				s_d.nib = 1'b0;
				s_d.shift = 7'h00;
			end
			else if (byte_in[4])
			begin
				if (byte_in[3])
					s_d.shift = lcdic_rot(s_q.shift, byte_in[2], s_q.two_line);
				else if (s_q.ac_glyph)
					s_d.ac = {1'b0, s_q.ac[5:0] + (byte_in[2] ? 6'h01 : 6'h3F)};
				else
					s_d.ac = lcdic_step(s_q.ac, byte_in[2], s_q.two_line);
			end
			else if (byte_in[3])
			begin
				s_d.disp_on = byte_in[2];
				s_d.cur_on = byte_in[1];
				s_d.blink_on = byte_in[0];
			end
			else if (byte_in[2])
			begin
				s_d.inc = byte_in[1];
				s_d.shift_en = byte_in[0];
			end
			else if (byte_in[1])
			begin
				s_d.ac = 7'h00;
				s_d.ac_glyph = 1'b0;
				s_d.shift = 7'h00;
				s_d.busy_cnt = 16'(CLEAR_CYCLES - 1);
			end
			else if (byte_in[0])
			begin
				s_d.ac = 7'h00;
				s_d.ac_glyph = 1'b0;
				s_d.inc = 1'b1;
				s_d.shift = 7'h00;
				s_d.clearing = 1'b1;
				s_d.clr_idx = 7'h00;
				s_d.busy_cnt = 16'(CLEAR_CYCLES - 1);
			end
		end
		// ------------------------------------------------------------
		// blink timer
		// ------------------------------------------------------------
		if (s_q.blink_cnt == 23'(BLINK_CYCLES - 1))
		begin
			s_d.blink_cnt = 23'h00_0000;
			s_d.blink_ph = !s_q.blink_ph;
		end
		else
			s_d.blink_cnt = s_q.blink_cnt + 23'h00_0001;
		// ------------------------------------------------------------
		// segment scan: one dot per enable, 40 dots per common row
		// ------------------------------------------------------------
		chr = 3'(s_q.col / `LCDIC_DOTS);
		dot = 3'(s_q.col % `LCDIC_DOTS);
		line = s_q.two_line & s_q.row[3];
		grow = s_q.row[2:0];
		pa = lcdic_pos_addr(chr, line, s_q.shift, s_q.two_line);
		code = s_q.text[pa];
		if (code[7:4] == 4'h0)
			pat = s_q.glyph[{code[2:0], grow}][4:0];
		else
			pat = lcdic_fixed(code, grow);
		if (!s_q.ac_glyph && pa == s_q.ac && s_q.cur_on && grow == `LCDIC_CURSOR_ROW)
			pat = 5'h1F;
		if (!s_q.ac_glyph && pa == s_q.ac && s_q.blink_on && s_q.blink_ph)
			pat = 5'h1F;
		pixel = s_q.disp_on & pat[3'h4 - dot];
		last_row = s_q.two_line ? 4'hF : 4'h7;
		if (s_q.div_cnt == 16'(SCAN_DIV - 1))
		begin
			s_d.div_cnt = 16'h0000;
			s_d.sreg = {s_q.sreg[38:0], pixel};
			if (s_q.col == 6'(`LCDIC_SEG_COUNT - 1))
			begin
				s_d.col = 6'h00;
				s_d.seg = {s_q.sreg[38:0], pixel};
				s_d.com = 16'h0001 << s_q.row;
				s_d.row = (s_q.row >= last_row) ? 4'h0 : s_q.row + 4'h1;
			end
			else
				s_d.col = s_q.col + 6'h01;
		end
		else
			s_d.div_cnt = s_q.div_cnt + 16'h0001;
		// function set restarts the frame at row 0; a common latched before it still drives until its row ends
		if (exec_cmd && byte_in[7:5] == 3'b001)
			s_d.row = 4'h0;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.text <= {`LCDIC_TEXT_DEPTH{`LCDIC_SPACE_CODE}};
			s_q.inc <= 1'b1;
			s_q.bus8 <= 1'b1;
			s_q.hreadyout <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_busy_on_cmd: assert property (exec_cmd && cmd_byte != 8'h00 |=> s_q.busy)
		else $error("busy not raised after instruction");
	a_busy_hold: assert property ($fell(s_q.busy) |-> $past(s_q.busy_cnt) == 16'h0000)
		else $error("busy dropped before its time");
	a_clear_addr: assert property (exec_cmd && cmd_byte == 8'h01 |=> s_q.ac == 7'h00 && s_q.clearing && s_q.inc)
		else $error("clear did not reset counter");
	a_home_shift: assert property (exec_cmd && cmd_byte[7:1] == 7'h01 |=> s_q.ac == 7'h00 && s_q.shift == 7'h00)
		else $error("home did not restore");
	a_entry_bits: assert property (exec_cmd && cmd_byte[7:2] == 6'h01
		|=> s_q.inc == $past(cmd_byte[1]) && s_q.shift_en == $past(cmd_byte[0]))
		else $error("entry mode not latched");
	a_onoff_bits: assert property (exec_cmd && cmd_byte[7:3] == 5'h01
		|=> {s_q.disp_on, s_q.cur_on, s_q.blink_on} == $past(cmd_byte[2:0]))
		else $error("display control not latched");
	a_func_bits: assert property (exec_cmd && cmd_byte[7:5] == 3'h1
		|=> {s_q.bus8, s_q.two_line, s_q.tall_font} == $past(cmd_byte[4:2]))
		else $error("function set not latched");
	a_addr_load: assert property (exec_cmd && cmd_byte[7] |=> s_q.ac == $past(cmd_byte[6:0]) && !s_q.ac_glyph)
		else $error("text address not loaded");
	a_status_read: assert property (stat_rd && s_q.bus8 |=> s_q.hrdata[7:0] == $past({s_q.busy, s_q.ac}))
		else $error("status read wrong");
	a_data_step: assert property (exec_wr && s_q.ac_glyph && s_q.inc
		|=> s_q.ac[5:0] == $past(s_q.ac[5:0]) + 6'h01)
		else $error("counter did not step");
	a_seg_xfer: assert property (s_q.seg != $past(s_q.seg) |-> $past(s_q.col) == 6'(`LCDIC_SEG_COUNT - 1))
		else $error("segment latch changed mid row");
	a_com_onehot: assert property ($onehot0(s_q.com))
		else $error("common drive not one-hot");
	a_com_lines: assert property (s_q.com != $past(s_q.com) && !$past(s_q.two_line) |-> s_q.com[15:8] == 8'h00)
		else $error("upper commons driven in one-line mode");
	a_answer_time: assert property (take_q |=> !s_q.hreadyout ##1 s_q.hreadyout)
		else $error("bus answer late");

	c_clear: cover property (exec_cmd && cmd_byte == 8'h01);
	c_nibble_cmd: cover property (exec_cmd && !s_q.bus8);
	c_glyph_write: cover property (exec_wr && s_q.ac_glyph);
	c_disp_shift: cover property (exec_cmd && cmd_byte[7:3] == 5'h03);
endmodule : lcdic_core

// ==== lcdic_host.sv ====
// host processor model driving the core's register bus
module lcdic_host
(
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ps;
	logic nib_mode;
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
		nib_mode = 1'b0;
	end
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// hready is registered, so its level at the falling edge is what the next rising edge sees
	task automatic wait_ready(output logic [31:0] r);
		int n;
		n = 0;
		@(negedge mclk);
		while (hready !== 1'b1 && n < 50)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 50)
			hung = 1'b1;
		r = hrdata;
		@(posedge mclk);
	endtask : wait_ready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		logic [31:0] x;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready(x);
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_ready(r);
	endtask : xfer
	// ----------------------------------------------------------------
	// byte transfers, split into nibbles in narrow mode
	// ----------------------------------------------------------------
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		if (nib_mode)
		begin
			xfer(1'b1, a, {d[7:4], 4'h0}, r);
			xfer(1'b1, a, {d[3:0], 4'h0}, r);
		end
		else
			xfer(1'b1, a, d, r);
		if (a == 8'h00 && d[7:5] == 3'b001)
			nib_mode = !d[4];
	endtask : put
	task automatic get(input logic [7:0] a, output logic [7:0] v);
		logic [31:0] h;
		logic [31:0] l;
		xfer(1'b0, a, 8'h00, h);
		l = h << 4;
		if (nib_mode)
			xfer(1'b0, a, 8'h00, l);
		v = {h[7:4], l[7:4]};
	endtask : get
	// nothing is sent until the busy bit reads low
	task automatic poll();
		logic [7:0] s;
		int n;
		n = 0;
		get(8'h00, s);
		while (s[7] !== 1'b0 && n < 1000)
		begin
			get(8'h00, s);
			n++;
		end
		if (n >= 1000)
			hung = 1'b1;
	endtask : poll
endmodule : lcdic_host

// ==== char_lcd_instruction_core_tb.sv ====
// self-checking bench of the character display core
module char_lcd_instruction_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk;
	logic reset_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [39:0] seg_out;
	logic [15:0] com_out;
	logic hung;
	int failures = 0;
	int cmp_count = 0;
	int i;
	logic [31:0] r;
	lcdic_core #(.CLEAR_CYCLES(160), .BLINK_CYCLES(16), .SCAN_DIV(1)) u_dut
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.seg_out(seg_out),
		.com_out(com_out)
	);
	lcdic_host u_host
	(
		.mclk(mclk),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hung(hung)
	);
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ----------------------------------------------------------------
	// checking and report
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	always @(posedge hung)
	begin
		failures++;
		final_report();
	end
	// ----------------------------------------------------------------
	// access helpers
	// ----------------------------------------------------------------
	task automatic ins(input logic [7:0] c);
		u_host.put(8'h00, c);
		u_host.poll();
	endtask : ins
	task automatic sta(input logic [7:0] e);
		logic [7:0] v;
		u_host.get(8'h00, v);
		check({24'h0, v}, {24'h0, e});
	endtask : sta
	task automatic dat(input logic [7:0] e);
		logic [7:0] v;
		u_host.get(8'h04, v);
		check({24'h0, v}, {24'h0, e});
		u_host.poll();
	endtask : dat
	task automatic cfg(input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		u_host.xfer(1'b0, 8'h08, 8'h00, v);
		check(v & m, e);
	endtask : cfg
	// common lines seen over more than one full frame
	task automatic scan(input logic [15:0] e);
		logic [15:0] acc;
		acc = 16'h0000;
		repeat (1500)
		begin
			@(negedge mclk);
			acc = acc | com_out;
		end
		check({16'h0, acc}, {16'h0, e});
	endtask : scan
	// leftmost two cells as latched with common rows 0 and 1
	task automatic segs(input logic [9:0] e0, input logic [9:0] e1);
		logic [9:0] s0;
		logic [9:0] s1;
		s0 = 10'h155;
		s1 = 10'h155;
		repeat (700)
		begin
			@(negedge mclk);
			if (com_out[0])
				s0 = seg_out[39:30];
			if (com_out[1])
				s1 = seg_out[39:30];
		end
		check({22'h0, s0}, {22'h0, e0});
		check({22'h0, s1}, {22'h0, e1});
	endtask : segs
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset_n = 1'b0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		sta(8'h00);
		cfg(32'hFFFFFFFF, 32'h00000090);
		u_host.xfer(1'b0, 8'h0C, 8'h00, r);
		check(r, 32'h0);
		check({31'h0, hresp}, 32'h0);
		u_host.put(8'h00, 8'hC5);
		sta(8'hC5);
		u_host.put(8'h00, 8'h90); // refused while busy
		u_host.poll();
		sta(8'h45);
		u_host.put(8'h04, 8'h41);
		u_host.poll();
		sta(8'h46);
		u_host.put(8'h04, 8'h42);
		u_host.poll();
		ins(8'hC5);
		dat(8'h41);
		sta(8'h46);
		dat(8'h42);
		ins(8'h04);
		cfg(32'h18, 32'h00);
		ins(8'h90);
		u_host.put(8'h04, 8'h55);
		u_host.poll();
		sta(8'h0F);
		ins(8'h06);
		cfg(32'h18, 32'h10);
		ins(8'h48);
		u_host.put(8'h04, 8'h1F); // row 0 only, cursor row left zero
		u_host.poll();
		sta(8'h09);
		cfg(32'h8000, 32'h8000);
		ins(8'h48);
		dat(8'h1F);
		u_host.put(8'h04, 8'h10); // glyph 1 row 1: leftmost dot only
		u_host.poll();
		for (i = 0; i < 8; i++)
		begin
			ins(8'h08 | i[7:0]);
			cfg(32'h07, i);
		end
		ins(8'h80);
		u_host.put(8'h04, 8'h01);
		u_host.poll();
		u_host.put(8'h04, 8'h09);
		u_host.poll();
		ins(8'h0C);
		segs(10'h3FF, 10'h210);
		scan(16'h00FF);
		ins(8'h20);
		cfg(32'hE0, 32'h00);
		ins(8'h2C);
		cfg(32'hE0, 32'h60);
		ins(8'hB3);
		sta(8'h33);
		ins(8'h38);
		cfg(32'hE0, 32'hC0);
		scan(16'hFFFF);
		ins(8'hA7);
		ins(8'h14);
		sta(8'h40);
		ins(8'h10);
		sta(8'h27);
		ins(8'h1C);
		sta(8'h27);
		u_host.xfer(1'b0, 8'h08, 8'h00, r);
		check({31'h0, r[14:8] != 7'h00}, 32'h1);
		ins(8'h02);
		sta(8'h00);
		cfg(32'h7F00, 32'h0);
		ins(8'hC5);
		dat(8'h41);
		ins(8'h01);
		sta(8'h00);
		ins(8'hC5);
		dat(8'h20);
		final_report();
	end
endmodule : char_lcd_instruction_core_tb
